// [idle_sleep_pkg.sv]
// Constants shared by the idle and sleep control block
package idle_sleep_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFF_LEVEL_TWO   = 8'h00;
  localparam logic [7:0] OFF_LEVEL_THREE = 8'h04;
  localparam logic [7:0] OFF_CONTROL_TWO = 8'h08;
  localparam logic [7:0] OFF_STATUS_A    = 8'h0C;
  localparam logic [7:0] OFF_STATUS_B    = 8'h10;
  localparam logic [7:0] OFF_CONTROL_A   = 8'h14;
  localparam logic [7:0] OFF_CONTROL_B   = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h20;
  localparam logic [7:0] OFF_STATE       = 8'h24;
  localparam logic [7:0] OFF_SUPPORT     = 8'h28;

  // Field positions
  localparam int BIT_ARB_OFF     = 0;
  localparam int BIT_BM_WAKE_SEL = 1;
  localparam int BIT_BM_FLAG     = 4;
  localparam int BIT_WOKE_FLAG   = 15;
  localparam int BIT_SLEEP_START = 13;
  localparam int POS_SLEEP_TYPE  = 10;
  localparam int SLEEP_TYPE_W    = 3;

  // Interrupt status bits
  localparam int IRQ_IDLE_EXIT   = 0;
  localparam int IRQ_SLEEP_ENTER = 1;
  localparam int IRQ_WAKE        = 2;
  localparam int IRQ_W           = 3;

  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] READ_JUNK  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_RUN, ST_C1, ST_C2, ST_C3, ST_SLEEP
  } power_state_t;
endpackage

// [cpu_idle_sleep_control.sv]
// Processor idle-state and system sleep control with Wishbone registers
`timescale 1ns/1ps
// Function
// - Support C1 entered by halt; always leave C1 when an interrupt is due.
// - Reading the level-two entry register enters C2; leave on interrupt.
// - Reading level-three entry enters C3; leave on interrupt or wake-selected bus request.
// - In C3 caches keep contents and ignore snoops.
// - Control-two register holds arbitration-off bit that blocks bus-master cycles.
// - Bus-master activity flag readable in both first-group status registers.
// - Three-bit sleep type plus start bit; setting start from run with a supported type begins sleep.
// - Two control instances a and b, each with its own sleep type.
// - Each supported state maps to one sleep-type code pair.
// - Controller sequences power planes for the type written with the start bit.
// - Hardware sets the woke flag when a wake occurs during sleep.
// - Any enabled wake restarts system clocks and resumes the processor.
module cpu_idle_sleep_control
#(
  parameter logic [7:0] SUPPORT_MASK = 8'h3E // Supported sleep types 1..5
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // Processor side
  input  wire logic                  halt_i,
  input  wire logic                  irq_pending_i,
  input  wire logic                  bm_request_i,
  input  wire logic                  wake_event_i,
  output logic                       cpu_stop_o,
  output logic                       snoop_block_o,
  output logic                       arb_block_o,
  output logic                       clocks_stop_o,
  output logic      [idle_sleep_pkg::SLEEP_TYPE_W-1:0] plane_type_o,
  output logic                       plane_start_o,
  // Interrupt
  output logic                       irq_o
);
  import idle_sleep_pkg::*;

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire access   = cyc_i & stb_i & ~ack_o;
  wire rd       = access & ~we_i;
  wire wr       = access & we_i;
  wire hit_l2   = adr_i == OFF_LEVEL_TWO;
  wire hit_l3   = adr_i == OFF_LEVEL_THREE;
  wire hit_c2r  = adr_i == OFF_CONTROL_TWO;
  wire hit_sa   = adr_i == OFF_STATUS_A;
  wire hit_sb   = adr_i == OFF_STATUS_B;
  wire hit_ca   = adr_i == OFF_CONTROL_A;
  wire hit_cb   = adr_i == OFF_CONTROL_B;
  wire hit_is   = adr_i == OFF_IRQ_STATUS;
  wire hit_im   = adr_i == OFF_IRQ_MASK;
  wire hit_st   = adr_i == OFF_STATE;
  wire hit_sup  = adr_i == OFF_SUPPORT;
  wire wr_lo    = wr & sel_i[0];
  wire wr_hi    = wr & sel_i[1];

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  power_state_t state;
  power_state_t next_state;
  logic         arb_off;
  logic         bm_wake_sel;
  logic         bm_flag;
  logic         woke_flag;
  logic [SLEEP_TYPE_W-1:0] type_a;
  logic [SLEEP_TYPE_W-1:0] type_b;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // Sleep start: either instance, type and start bit in the same write
  wire start_a    = wr_hi & hit_ca & dat_i[BIT_SLEEP_START];
  wire start_b    = wr_hi & hit_cb & dat_i[BIT_SLEEP_START];
  wire [SLEEP_TYPE_W-1:0] wr_type = dat_i[POS_SLEEP_TYPE +: SLEEP_TYPE_W];
  wire type_ok    = SUPPORT_MASK[wr_type];
  wire sleep_go   = (start_a | start_b) & type_ok & (state == ST_RUN);
  wire idle_st    = (state == ST_C1) | (state == ST_C2) | (state == ST_C3);
  wire c3_exit    = irq_pending_i | (bm_wake_sel & bm_request_i);
  wire idle_exit  = ((state == ST_C1) | (state == ST_C2)) ? irq_pending_i
                                                          : c3_exit;
  wire wake_now   = (state == ST_SLEEP) & wake_event_i;
  wire bm_seen    = bm_request_i & ~arb_off;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleep_go) begin
          next_state = ST_SLEEP;
        end else if (rd & hit_l3) begin
          next_state = ST_C3;
        end else if (rd & hit_l2) begin
          next_state = ST_C2;
        end else if (halt_i & ~irq_pending_i) begin
          next_state = ST_C1;
        end
      end
      ST_C1, ST_C2, ST_C3: begin
        if (idle_exit) begin
          next_state = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_event_i) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb_off     <= 1'b0;
      bm_wake_sel <= 1'b0;
    end else if (wr_lo & hit_c2r) begin
      arb_off     <= dat_i[BIT_ARB_OFF];
      bm_wake_sel <= dat_i[BIT_BM_WAKE_SEL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      type_a <= '0;
      type_b <= '0;
    end else begin
      if (wr_hi & hit_ca) begin
        type_a <= wr_type;
      end
      if (wr_hi & hit_cb) begin
        type_b <= wr_type;
      end
    end
  end

  // Status flags: set wins over write-one-to-clear
  wire clr_bm   = wr_lo & (hit_sa | hit_sb) & dat_i[BIT_BM_FLAG];
  wire clr_woke = wr_hi & (hit_sa | hit_sb) & dat_i[BIT_WOKE_FLAG];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bm_flag   <= 1'b0;
      woke_flag <= 1'b0;
    end else begin
      bm_flag   <= bm_seen | (bm_flag & ~clr_bm);
      woke_flag <= wake_now | (woke_flag & ~clr_woke);
    end
  end

  // --------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------
  wire [IRQ_W-1:0] irq_set = {wake_now, sleep_go, idle_st & idle_exit};
  wire irq_rd_clr = rd & hit_is;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= irq_set | (irq_status & {IRQ_W{~irq_rd_clr}});
      if (wr_lo & hit_im) begin
        irq_mask <= dat_i[IRQ_W-1:0];
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // --------------------------------------------------------------
  // Outputs toward the platform
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_stop_o    <= 1'b0;
      snoop_block_o <= 1'b0;
      arb_block_o   <= 1'b0;
      clocks_stop_o <= 1'b0;
      plane_type_o  <= '0;
      plane_start_o <= 1'b0;
    end else begin
      cpu_stop_o    <= (next_state != ST_RUN);
      snoop_block_o <= (next_state == ST_C3);
      arb_block_o   <= (wr_lo & hit_c2r) ? dat_i[BIT_ARB_OFF] : arb_off;
      clocks_stop_o <= (next_state == ST_SLEEP);
      plane_start_o <= sleep_go;
      if (sleep_go) begin
        plane_type_o <= wr_type;
      end
    end
  end

  // --------------------------------------------------------------
  // Read data and acknowledge
  // --------------------------------------------------------------
  wire [31:0] status_word = RESET_ZERO | ({31'h0000_0000, woke_flag} << BIT_WOKE_FLAG)
                          | ({31'h0000_0000, bm_flag} << BIT_BM_FLAG);
  wire [31:0] ctl2_word   = RESET_ZERO | ({31'h0000_0000, arb_off} << BIT_ARB_OFF)
                          | ({31'h0000_0000, bm_wake_sel} << BIT_BM_WAKE_SEL);
  wire [31:0] ctl_a_word  = {29'h0000_0000, type_a} << POS_SLEEP_TYPE;
  wire [31:0] ctl_b_word  = {29'h0000_0000, type_b} << POS_SLEEP_TYPE;
  wire [31:0] rdata =
      (hit_l2 | hit_l3) ? READ_JUNK :
      hit_c2r ? ctl2_word :
      (hit_sa | hit_sb) ? status_word :
      hit_ca  ? ctl_a_word :
      hit_cb  ? ctl_b_word :
      hit_is  ? {29'h0000_0000, irq_status} :
      hit_im  ? {29'h0000_0000, irq_mask} :
      hit_st  ? {29'h0000_0000, state} :
      hit_sup ? {24'h00_0000, SUPPORT_MASK} : RESET_ZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= RESET_ZERO;
    end else begin
      ack_o <= access;
      dat_o <= rd ? rdata : RESET_ZERO;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_idle_irq_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_C1 || state == ST_C2) && irq_pending_i |=> state == ST_RUN)
    else $error("idle state not left on interrupt");
  a_c3_bm_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_C3 && bm_wake_sel && bm_request_i |=> state == ST_RUN)
    else $error("C3 not left on bus master request");
  a_l2_read_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_RUN && rd && hit_l2 && !sleep_go |=> state == ST_C2 && cpu_stop_o)
    else $error("C2 not entered by read");
  a_c3_snoop_block: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_C3 && !c3_exit |=> snoop_block_o)
    else $error("snoops not blocked in C3");
  a_arb_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lo && hit_c2r |=> arb_block_o == $past(dat_i[BIT_ARB_OFF]))
    else $error("arbitration block mismatch");
  a_bm_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    bm_request_i && !arb_off |=> bm_flag)
    else $error("bus master flag not set");
  a_sleep_start: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_go |=> plane_start_o && plane_type_o == $past(wr_type) && clocks_stop_o)
    else $error("sleep start not sequenced");
  a_woke_set: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_now |=> woke_flag && state == ST_RUN)
    else $error("woke flag not set on wake");
  a_unsupported_type: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_a || start_b) && !type_ok && state == ST_RUN |=> state != ST_SLEEP)
    else $error("unsupported sleep type accepted");

  // --------------------------------------------------------------
  // Checks on idle states
  // --------------------------------------------------------------
  a_c1_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_RUN && halt_i && !irq_pending_i && !sleep_go && !(rd && (hit_l2 || hit_l3))
    |=> state == ST_C1)
    else $error("halt not taken into C1");

  a_c1_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_C1 && !irq_pending_i |=> state == ST_C1 && cpu_stop_o)
    else $error("C1 left without cause");

  a_c2_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_C2 && !irq_pending_i |=> state == ST_C2 && cpu_stop_o)
    else $error("C2 left without cause");

  a_l3_read_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_RUN && rd && hit_l3 && !sleep_go |=> state == ST_C3 && snoop_block_o && cpu_stop_o)
    else $error("C3 not entered by read");

  a_c3_irq_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_C3 && irq_pending_i |=> state == ST_RUN && !snoop_block_o)
    else $error("C3 not left on interrupt");

  a_c3_no_bm_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_C3 && !irq_pending_i && !bm_wake_sel |=> state == ST_C3 && snoop_block_o)
    else $error("C3 left on unselected bus master request");

  a_idle_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && (hit_l2 || hit_l3) |=> dat_o == READ_JUNK)
    else $error("idle entry read returned data");

  // --------------------------------------------------------------
  // Checks on bus masters and sleep
  // --------------------------------------------------------------
  a_arb_gates_bm: assert property (@(posedge clk_i) disable iff (rst_i)
    arb_off && !bm_flag |=> !bm_flag)
    else $error("bus master flag set while arbitration is off");

  a_bm_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && (hit_sa || hit_sb) |=> dat_o[BIT_BM_FLAG] == $past(bm_flag))
    else $error("bus master flag not readable");

  a_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_SLEEP && !wake_event_i |=> state == ST_SLEEP && clocks_stop_o)
    else $error("sleep left without wake");

  a_type_a_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hi && hit_ca |=> type_a == $past(wr_type))
    else $error("sleep type a not stored");

  a_type_b_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hi && hit_cb |=> type_b == $past(wr_type))
    else $error("sleep type b not stored");

  a_plane_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !sleep_go |=> !plane_start_o)
    else $error("plane sequencing started without sleep start");

  a_woke_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    woke_flag && !clr_woke |=> woke_flag)
    else $error("woke flag lost without clear");

  a_sleep_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_SLEEP && wake_event_i |=> state == ST_RUN && !clocks_stop_o && !cpu_stop_o)
    else $error("clocks not restarted on wake");
endmodule // cpu_idle_sleep_control

// [cpu_side_model.sv]
// Processor, bus-master and power-plane controller stand-in
`timescale 1ns/1ps
module cpu_side_model (
  // Clock, reset and bench commands
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] cmd_i,
  // Block side
  input  wire logic       plane_start_i,
  input  wire logic [2:0] plane_type_i,
  output logic            halt_o,
  output logic            irq_pending_o,
  output logic            bm_request_o,
  output logic            wake_event_o,
  output logic [7:0]      start_count_o,
  output logic [2:0]      seen_type_o
);
  // ----------------------------------------
  // Core and bus-master lines, one cycle behind the bench
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {wake_event_o, bm_request_o, irq_pending_o, halt_o} <= 4'h0;
    end else begin
      {wake_event_o, bm_request_o, irq_pending_o, halt_o} <= cmd_i;
    end
  end
  // ----------------------------------------
  // Controller counts starts and keeps the announced type
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_count_o <= 8'h00;
      seen_type_o   <= 3'h0;
    end else if (plane_start_i) begin
      start_count_o <= start_count_o + 8'h01;
      seen_type_o   <= plane_type_i;
    end
  end
endmodule // cpu_side_model

// [cpu_idle_sleep_control_tb.sv]
// Self-checking bench for the idle and sleep control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module cpu_idle_sleep_control_tb;
  import idle_sleep_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, cstop, snoop, arb, clk_stop;
  logic halt, irqp, bm, wake, pstart;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, q;
  logic [3:0]  cmd = 4'h0, sel = 4'hF;
  logic [2:0]  ptype, seen;
  logic [7:0]  starts;
  int          mismatches = 0, total_checks = 0;
  always #25 clk_i = ~clk_i;
  cpu_idle_sleep_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .halt_i(halt), .irq_pending_i(irqp), .bm_request_i(bm), .wake_event_i(wake),
    .cpu_stop_o(cstop), .snoop_block_o(snoop), .arb_block_o(arb), .clocks_stop_o(clk_stop),
    .plane_type_o(ptype), .plane_start_o(pstart), .irq_o(irq));
  cpu_side_model i_far (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .plane_start_i(pstart),
    .plane_type_i(ptype), .halt_o(halt), .irq_pending_o(irqp), .bm_request_o(bm),
    .wake_event_o(wake), .start_count_o(starts), .seen_type_o(seen));
  // ----------------------------------------
  // Bus and timing helpers
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    wb(0, OFF_STATE, 0);   `CHK(q, 32'h0000_0000)
    wb(0, OFF_SUPPORT, 0); `CHK(q, 32'h0000_003E)
    wb(1, 8'hFC, 32'hFFFF_FFFF);
    wb(0, 8'hFC, 0);       `CHK(q, 32'h0000_0000)
    wb(1, OFF_CONTROL_TWO, 32'h0000_0001, 4'h0); tick(1); `CHK(arb, 1'b0)
  endtask
  task automatic t_c1();
    wb(1, OFF_IRQ_MASK, 32'h0000_0007);
    cmd <= 4'h1; tick(3);
    wb(0, OFF_STATE, 0); `CHK(q, 32'h0000_0001)
    cmd <= 4'h3; tick(3); `CHK(cstop, 1'b0)
    cmd <= 4'h0; tick(1); `CHK(irq, 1'b1)
    wb(0, OFF_IRQ_STATUS, 0); `CHK(q, 32'h0000_0001)
    tick(2); `CHK(irq, 1'b0)
  endtask
  task automatic t_c2();
    wb(1, OFF_IRQ_MASK, 32'h0000_0000);
    wb(0, OFF_LEVEL_TWO, 0); `CHK(q, READ_JUNK)
    tick(1); `CHK(cstop, 1'b1)
    wb(0, OFF_STATE, 0); `CHK(q, 32'h0000_0002)
    cmd <= 4'h2; tick(3); `CHK(cstop, 1'b0)
    `CHK(irq, 1'b0)
    cmd <= 4'h0; wb(0, OFF_IRQ_STATUS, 0); `CHK(q, 32'h0000_0001)
  endtask
  task automatic t_c3();
    wb(1, OFF_CONTROL_TWO, 32'h0000_0003); tick(1); `CHK(arb, 1'b1)
    wb(0, OFF_LEVEL_THREE, 0); tick(1); `CHK(snoop, 1'b1)
    wb(0, OFF_STATE, 0); `CHK(q, 32'h0000_0003)
    cmd <= 4'h4; tick(3); `CHK(snoop, 1'b0)
    `CHK(cstop, 1'b0)
    wb(0, OFF_STATUS_A, 0); `CHK(q, 32'h0000_0000)
    wb(1, OFF_CONTROL_TWO, 32'h0000_0000); tick(1); `CHK(arb, 1'b0)
    wb(0, OFF_STATUS_A, 0); `CHK(q, 32'h0000_0010)
    wb(0, OFF_STATUS_B, 0); `CHK(q, 32'h0000_0010)
    cmd <= 4'h0; tick(2);
    wb(1, OFF_STATUS_A, 32'h0000_0010); wb(1, OFF_STATUS_B, 32'h0000_0010);
    wb(0, OFF_STATUS_A, 0); `CHK(q, 32'h0000_0000)
    wb(1, OFF_CONTROL_TWO, 32'h0000_0001); wb(0, OFF_LEVEL_THREE, 0);
    cmd <= 4'h4; tick(3); `CHK(snoop, 1'b1)
    cmd <= 4'h2; tick(3); `CHK(snoop, 1'b0)
    cmd <= 4'h0; wb(1, OFF_CONTROL_TWO, 32'h0000_0000);
  endtask
  task automatic t_sleep();
    logic [7:0]  n;
    logic [7:0]  off [2] = '{OFF_CONTROL_A, OFF_CONTROL_B};
    logic [2:0]  typ [2] = '{3'h3, 3'h5};
    wb(0, OFF_IRQ_STATUS, 0);
    for (int i = 0; i < 2; i++) begin
      n = starts;
      wb(1, off[i], ({29'h0, typ[i]} << POS_SLEEP_TYPE) | 32'h0000_2000);
      tick(2); `CHK(starts, n + 8'h01)
      `CHK(seen, typ[i])
      `CHK(clk_stop, 1'b1)
      wb(0, OFF_STATE, 0); `CHK(q, 32'h0000_0004)
      cmd <= 4'h8; tick(3); cmd <= 4'h0; `CHK(clk_stop, 1'b0)
      `CHK(cstop, 1'b0)
      wb(0, OFF_STATUS_A, 0); `CHK(q[BIT_WOKE_FLAG], 1'b1)
      wb(0, OFF_IRQ_STATUS, 0); `CHK(q, 32'h0000_0006)
      wb(1, OFF_STATUS_A, 32'h0000_8000);
    end
    n = starts;
    wb(1, OFF_CONTROL_A, 32'h0000_2000); tick(3); `CHK(starts, n)
    `CHK(clk_stop, 1'b0)
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(10);
    rst_i <= 1'b0;
    t_reset();
    t_c1();
    t_c2();
    t_c3();
    t_sleep();
    summarize();
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule // cpu_idle_sleep_control_tb
